//--- inc/conv_ctrl_pkg.sv
/*
  Types shared by the converter control block.
  Assumes the register header is included by the files that need offsets.
*/
package conv_ctrl_pkg;

  typedef enum logic [1:0]
  {
    CLK_SYSTEM_DIV2,
    CLK_SYSTEM_DIV4,
    CLK_DEDICATED_RC,
    CLK_SYSTEM_DIV8
  } conv_clk_type;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_DELAY,
    ST_CONVERT,
    ST_FINISH
  } conv_state_type;

endpackage : conv_ctrl_pkg

//--- inc/conv_ctrl_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  converter sleep and auto-trigger control block.
  Assumes a 32-bit APB bus with one aligned word per register.
*/
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH

`define CTRL_OFFSET        12'h000
`define TRIG_SEL_OFFSET    12'h004
`define STATUS_OFFSET      12'h008
`define INT_MASK_OFFSET    12'h00c
`define CONV_TIME_OFFSET   12'h010

`define CTRL_ON_BIT        0
`define CTRL_GO_BIT        1
`define CTRL_CLK_LSB       2
`define CTRL_IE_BIT        4
`define CTRL_SLEEP_BIT     5
`define CTRL_PEND_BIT      6
`define CTRL_POWERED_BIT   7

`define STAT_DONE_BIT      0
`define STAT_WAKE_BIT      1
`define STAT_PEND_BIT      2

`define TRIG_SEL_WIDTH     5
`define CONV_TIME_RESET    8'h0c
`define RC_EXTRA_CYCLES    4'h1
`define INSTR_DIV          4'h3

`endif

//--- src/conv_ctrl.sv
/*
  Converter sleep and auto-trigger control with an APB register slave.
  Assumes an APB master on pclk and trigger sources synchronous to pclk.
*/
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_regs.svh"

module conv_ctrl
  import conv_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Device state and triggers.
  input  wire logic        sleeping,
  input  wire logic [31:0] trig_sources,
  // Converter handshake.
  input  wire logic        conv_complete,
  output logic             conv_start,
  output logic             converter_powered,
  // System outputs.
  output logic             wake_request,
  output logic             irq
);

  conv_clk_type   clk_sel_reg;
  conv_state_type state_reg;
  logic           converter_on_reg;
  logic           conversion_go_reg;
  logic           int_enable_reg;
  logic           pending_reg;
  logic           off_reg;
  logic [4:0]     auto_trigger_select_reg;
  logic [2:0]     status_reg;
  logic [2:0]     mask_reg;
  logic [7:0]     conv_time_reg;
  logic [7:0]     count_reg;
  logic [3:0]     delay_reg;
  logic           sleep_conv_reg;
  logic           tick;
  logic           trig_rise;
  logic           wr;
  logic           rd;
  logic           rc_clk;
  logic           can_run;
  logic           done_evt;
  logic           wake_evt;
  logic           pend_evt;
  logic           go_write;
  logic [31:0]    rdata_next;
  logic           mapped;

  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~penable & ~pwrite;
  assign rc_clk  = (clk_sel_reg == CLK_DEDICATED_RC);
  assign can_run = ~sleeping | rc_clk;
  assign go_write = wr & (paddr == `CTRL_OFFSET) & pwdata[`CTRL_GO_BIT];

  instr_tick instr_tick_i
  (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  trig_edge trig_edge_i
  (
    .pclk    (pclk),
    .presetn (presetn),
    .sources (trig_sources),
    .select  (auto_trigger_select_reg),
    .rise    (trig_rise)
  );

  // Completion events of a finished conversion, and the pending-trigger event.
  assign done_evt = (state_reg == ST_FINISH);
  assign wake_evt = done_evt & sleep_conv_reg & int_enable_reg;
  assign pend_evt = trig_rise & sleeping & ~rc_clk & converter_on_reg;

  // Control, trigger select, mask and conversion time registers written by software.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      converter_on_reg <= 1'b0;
      clk_sel_reg      <= CLK_SYSTEM_DIV2;
      int_enable_reg   <= 1'b0;
      auto_trigger_select_reg <= 5'h00;
      mask_reg         <= 3'h0;
      conv_time_reg    <= `CONV_TIME_RESET;
    end
    else if (wr)
    begin
      case (paddr)
        `CTRL_OFFSET:
        begin
          converter_on_reg <= pwdata[`CTRL_ON_BIT];
          clk_sel_reg      <= conv_clk_type'(pwdata[`CTRL_CLK_LSB +: 2]);
          int_enable_reg   <= pwdata[`CTRL_IE_BIT];
        end
        `TRIG_SEL_OFFSET:
          auto_trigger_select_reg <= pwdata[`TRIG_SEL_WIDTH-1:0];
        `INT_MASK_OFFSET:
          mask_reg <= pwdata[2:0];
        `CONV_TIME_OFFSET:
          conv_time_reg <= pwdata[7:0];
        default:
          mask_reg <= mask_reg;
      endcase
    end
  end

  // Go bit: set by software or trigger, cleared at completion.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conversion_go_reg <= 1'b0;
    else if (go_write | (trig_rise & converter_on_reg & can_run))
      conversion_go_reg <= 1'b1;
    else if (pending_reg & ~sleeping)
      conversion_go_reg <= 1'b1;
    else if (done_evt)
      conversion_go_reg <= 1'b0;
  end

  // Trigger held while asleep on a clock that cannot run.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_reg <= 1'b0;
    else if (pend_evt)
      pending_reg <= 1'b1;
    else if (~sleeping)
      pending_reg <= 1'b0;
  end

  // Converter power: off after an unannounced sleep conversion.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      off_reg <= 1'b0;
    else if (done_evt & sleep_conv_reg & ~int_enable_reg)
      off_reg <= 1'b1;
    else if (~sleeping | ~converter_on_reg)
      off_reg <= 1'b0;
  end

  // Conversion sequencer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg      <= ST_IDLE;
      count_reg      <= 8'h00;
      delay_reg      <= 4'h0;
      sleep_conv_reg <= 1'b0;
      conv_start     <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      case (state_reg)
        ST_IDLE:
          if (conversion_go_reg & converter_on_reg & ~off_reg & can_run)
          begin
            delay_reg <= rc_clk ? `RC_EXTRA_CYCLES : 4'h0;
            state_reg <= ST_DELAY;
          end
        ST_DELAY:
          if (delay_reg == 4'h0)
          begin
            sleep_conv_reg <= sleeping;
            count_reg      <= conv_time_reg;
            conv_start     <= 1'b1;
            state_reg      <= ST_CONVERT;
          end
          else if (tick)
            delay_reg <= delay_reg - 4'h1;
        ST_CONVERT:
        begin
          sleep_conv_reg <= sleep_conv_reg | sleeping;
          if (conv_complete | (count_reg == 8'h00))
            state_reg <= ST_FINISH;
          else
            count_reg <= count_reg - 8'h01;
        end
        ST_FINISH:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Sticky status, set wins over write-one-to-clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= 3'h0;
    else
    begin
      if (wr & (paddr == `STATUS_OFFSET))
        status_reg <= (status_reg & ~pwdata[2:0])
                      | {pend_evt, wake_evt, done_evt};
      else
        status_reg <= status_reg | {pend_evt, wake_evt, done_evt};
    end
  end

  // Outputs from flip-flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_request      <= 1'b0;
      irq               <= 1'b0;
      converter_powered <= 1'b0;
    end
    else
    begin
      wake_request      <= wake_evt;
      irq               <= |(status_reg & mask_reg);
      converter_powered <= converter_on_reg & ~off_reg;
    end
  end

  // Read data mux.
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    mapped     = 1'b1;
    case (paddr)
      `CTRL_OFFSET:
      begin
        rdata_next[`CTRL_ON_BIT]              = converter_on_reg;
        rdata_next[`CTRL_GO_BIT]              = conversion_go_reg;
        rdata_next[`CTRL_CLK_LSB +: 2]        = clk_sel_reg;
        rdata_next[`CTRL_IE_BIT]              = int_enable_reg;
        rdata_next[`CTRL_SLEEP_BIT]           = sleeping;
        rdata_next[`CTRL_PEND_BIT]            = pending_reg;
        rdata_next[`CTRL_POWERED_BIT]         = converter_on_reg & ~off_reg;
      end
      `TRIG_SEL_OFFSET:
        rdata_next[4:0] = auto_trigger_select_reg;
      `STATUS_OFFSET:
        rdata_next[2:0] = status_reg;
      `INT_MASK_OFFSET:
        rdata_next[2:0] = mask_reg;
      `CONV_TIME_OFFSET:
        rdata_next[7:0] = conv_time_reg;
      default:
        mapped = 1'b0;
    endcase
  end

  // APB answer: no wait state, read data captured in setup.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd)
        prdata <= rdata_next;
    end
  end

endmodule : conv_ctrl
`default_nettype wire

//--- src/instr_tick.sv
/*
  Divider that gives a one-cycle enable pulse per instruction cycle.
  Assumes a single free-running clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_regs.svh"

module instr_tick
(
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Enable pulse.
  output logic      tick
);

  logic [3:0] count_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= 4'h0;
      tick      <= 1'b0;
    end
    else
    begin
      tick <= (count_reg == `INSTR_DIV);
      if (count_reg == `INSTR_DIV)
        count_reg <= 4'h0;
      else
        count_reg <= count_reg + 4'h1;
    end
  end

endmodule : instr_tick
`default_nettype wire

//--- src/trig_edge.sv
/*
  Selects one of thirty-two trigger sources and detects its rising edge.
  Assumes trigger sources are synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_regs.svh"

module trig_edge
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Sources and select.
  input  wire logic [31:0] sources,
  input  wire logic [4:0]  select,
  // Edge pulse.
  output logic             rise
);

  logic prev_reg;
  logic cur;

  assign cur = sources[select];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_reg <= 1'b0;
    else
      prev_reg <= cur;
  end

  assign rise = cur & ~prev_reg;

endmodule : trig_edge
`default_nettype wire

//--- test/conv_ctrl_checker.sv
/*
  Checker for the converter control block.
  Bound to conv_ctrl; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_regs.svh"

module conv_ctrl_checker
  import conv_ctrl_pkg::*;
(
  // Watched ports.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleeping,
  input wire logic        conv_start,
  input wire logic        converter_powered,
  input wire logic        wake_request
);
  logic       on_q;
  logic       ie_q;
  logic [1:0] clk_q;
  logic       wr;
  logic       rc;

  // Shadow of the control word as software last wrote it.
  assign wr = psel && penable && pwrite && pready
              && paddr == `CTRL_OFFSET;
  assign rc = pwdata[3:2] == CLK_DEDICATED_RC;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {on_q, ie_q, clk_q} <= '0;
    else if (wr)
      {on_q, ie_q, clk_q} <= {pwdata[0], pwdata[4], pwdata[3:2]};

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_answer;
    psel && !penable |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("late ready");
  property p_refuse;
    psel && penable && paddr > `CONV_TIME_OFFSET |-> pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("no error");
  property p_rc_wait;
    wr && pwdata[1] && rc |=> !conv_start [*3];
  endproperty
  a_rc_wait: assert property (p_rc_wait) else $error("early");
  property p_fast;
    wr && pwdata[1:0] == 2'h3 && !rc && !sleeping && converter_powered
      |-> ##[1:4] conv_start;
  endproperty
  a_fast: assert property (p_fast) else $error("no start");
  property p_asleep;
    sleeping && $past(sleeping) && clk_q != CLK_DEDICATED_RC
      |-> !conv_start;
  endproperty
  a_asleep: assert property (p_asleep) else $error("slept");
  property p_wake;
    wake_request |-> ie_q && $past(sleeping);
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_wake_once;
    wake_request |=> !wake_request;
  endproperty
  a_wake_once: assert property (p_wake_once) else $error("wk");
  property p_start_once;
    conv_start |=> !conv_start;
  endproperty
  a_start_once: assert property (p_start_once) else $error("st");
  property p_power;
    $fell(converter_powered) |-> !on_q || $past(sleeping) && !ie_q;
  endproperty
  a_power: assert property (p_power) else $error("power off");
endmodule : conv_ctrl_checker

bind conv_ctrl conv_ctrl_checker conv_ctrl_checker_i
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .sleeping, .conv_start, .converter_powered, .wake_request
);
`default_nettype wire

//--- test/tb.sv
/*
  Self-checking bench for the converter control block.
  Drives APB, sleep and trigger inputs itself.
*/
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_regs.svh"

module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleeping;
  logic [31:0] trig_sources;
  logic        conv_complete;
  logic        conv_start;
  logic        converter_powered;
  logic        wake_request;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [2:0]  obs;
  int          n;
  int          fail_count;
  int          comparisons;

  assign obs = {irq, wake_request, conv_start};

  conv_ctrl conv_ctrl_i
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sleeping, .trig_sources,
    .conv_complete, .conv_start, .converter_powered,
    .wake_request, .irq
  );

  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wt(input int k, input int lim);
    n = 0;
    while (obs[k] !== 1'h1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : wt

  task automatic wdone();
    rd = '0;
    for (int i = 0; i < 40 && rd[0] !== 1'h1; i++)
      apb(1'h0, `STATUS_OFFSET, '0);
  endtask : wdone

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    #50us;
    fail_count++;
    print_verdict();
  end

  initial
  begin
    {psel, penable, pwrite, sleeping, conv_complete, presetn} = '0;
    {paddr, pwdata, trig_sources, fail_count, comparisons} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `CONV_TIME_OFFSET, '0);
    chk(rd, 32'h0c);
    apb(1'h0, `CTRL_OFFSET, '0);
    chk(rd, 32'h0);
    apb(1'h1, 12'h020, 32'h1);
    chk(err, 32'h1);
    apb(1'h0, 12'h020, '0);
    chk(rd, 32'h0);
    $display("reset test done");
    apb(1'h1, `CONV_TIME_OFFSET, 32'h4);
    apb(1'h1, `CTRL_OFFSET, 32'h1);
    apb(1'h1, `CTRL_OFFSET, 32'h3);
    wt(0, 10);
    chk(n < 10, 32'h1);
    wdone();
    chk(rd[0], 32'h1);
    apb(1'h0, `CTRL_OFFSET, '0);
    chk(rd[1], 32'h0);
    apb(1'h1, `STATUS_OFFSET, 32'h7);
    apb(1'h1, `CTRL_OFFSET, 32'h0b);
    wt(0, 100);
    chk(n > 3 && n < 100, 32'h1);
    wdone();
    apb(1'h1, `STATUS_OFFSET, 32'h7);
    $display("awake test done");
    apb(1'h1, `INT_MASK_OFFSET, 32'h1);
    sleeping <= 1'h1;
    apb(1'h1, `CTRL_OFFSET, 32'h1b);
    wt(1, 100);
    chk(n < 100, 32'h1);
    sleeping <= 1'h0;
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    apb(1'h1, `STATUS_OFFSET, 32'h7);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    $display("wake test done");
    apb(1'h1, `INT_MASK_OFFSET, 32'h0);
    apb(1'h1, `TRIG_SEL_OFFSET, 32'h5);
    sleeping <= 1'h1;
    apb(1'h1, `CTRL_OFFSET, 32'h09);
    trig_sources[5] <= 1'h1;
    wt(0, 100);
    chk(n < 100, 32'h1);
    wdone();
    chk(rd[0], 32'h1);
    chk({irq, converter_powered}, 32'h0);
    apb(1'h0, `CTRL_OFFSET, '0);
    chk(rd[0], 32'h1);
    sleeping <= 1'h0;
    trig_sources <= '0;
    apb(1'h1, `STATUS_OFFSET, 32'h7);
    chk(converter_powered, 32'h1);
    $display("power test done");
    apb(1'h1, `TRIG_SEL_OFFSET, 32'h1f);
    apb(1'h1, `CTRL_OFFSET, 32'h1);
    sleeping <= 1'h1;
    trig_sources[31] <= 1'h1;
    wt(0, 40);
    chk(n, 32'd40);
    apb(1'h0, `STATUS_OFFSET, '0);
    chk(rd[2], 32'h1);
    sleeping <= 1'h0;
    wt(0, 20);
    chk(n < 20, 32'h1);
    wdone();
    apb(1'h1, `STATUS_OFFSET, 32'h7);
    trig_sources <= '0;
    apb(1'h0, `STATUS_OFFSET, '0);
    trig_sources[15] <= 1'h1;
    wt(0, 20);
    chk(n, 32'd20);
    trig_sources[31] <= 1'h1;
    wt(0, 20);
    chk(n < 20, 32'h1);
    wdone();
    apb(1'h0, `CTRL_OFFSET, '0);
    chk(rd[1], 32'h0);
    $display("trigger test done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
